// *** logic/ssp_oe_pkg.sv ***
/*
  Constants and carrier types for the serial port slave-select and
  output-enable block. Assumes one clock domain (clk_sys) inside the device.
*/
// Summary of operation
// - Slave mode with select control: select input high resets the serial shift logic.
// - Port-C direction bit 5 reads back from the serial port output-enable signal.
// - Read-modify-write of direction while select high sets bit 5, stopping data out.
// - Port-A bit 5 selectable as active-low slave select, general I/O or analog.
// - Port-C bit 3 is the serial clock, input or output.
// - Port-C bit 4 carries serial data in, port-C bit 5 serial data out.
`default_nettype none
package serial_oe_pkg;

  // ==========================================================================
  // Mode field encodings
  localparam logic [3:0] MODE_MASTER_MAX  = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SEL   = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSEL = 4'h5;

  // ==========================================================================
  // Master clock half periods, in clk_sys cycles, per master mode
  localparam logic [6:0] HALF_DIV_0 = 7'h02;
  localparam logic [6:0] HALF_DIV_1 = 7'h08;
  localparam logic [6:0] HALF_DIV_2 = 7'h20;
  localparam logic [6:0] HALF_DIV_3 = 7'h40;

  // ==========================================================================
  // Port-C direction register layout
  localparam int         DIR_SCK_BIT   = 3;
  localparam int         DIR_DOUT_BIT  = 5;
  localparam logic [7:0] DIR_RESET_VAL = 8'hff;
  localparam logic [3:0] BIT_LAST      = 4'h7;

  // ==========================================================================
  // Port-A bit 5 function select
  typedef enum logic [1:0] {
    PA5_GPIO,
    PA5_ANALOG,
    PA5_SLAVE_SEL
  } pa5_func_t;

  typedef struct packed {
    logic       enable;
    logic [3:0] mode;
    logic       clockEdge;
    pa5_func_t  pa5Func;
  } port_cfg_t;

  typedef struct packed {
    logic rxFull;
    logic writeCollision;
    logic cfgError;
    logic periphOe;
  } port_status_t;

endpackage : serial_oe_pkg
`default_nettype wire

// *** logic/bit_sync.sv ***
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level or a clock far below clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      syncOut  <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
    end
  end

endmodule : bit_sync
`default_nettype wire

// *** logic/spi_slave_select_oe_control.sv ***
/*
  Synchronous serial port in SPI mode with slave-select handling and the
  output-enable path into the port-C direction read-back.
  Assumes the external master's clock is far slower than clk_sys, so that
  edges are found by sampling, and that software avoids illegal modes.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_slave_select_oe_control (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  // Configuration and status
  input  wire serial_oe_pkg::port_cfg_t cfg,
  output var  serial_oe_pkg::port_status_t status,
  // Port-C direction register access
  input  wire logic                    dirWrEn,
  input  wire logic [7:0]              dirWrData,
  output logic      [7:0]              dirRdData,
  // Transmit and receive data
  input  wire logic                    txWrite,
  input  wire logic [7:0]              txData,
  input  wire logic                    rxRead,
  output logic      [7:0]              rxData,
  // Pins
  input  wire logic                    port_a_bit5,
  input  wire logic                    portCBit3In,
  output logic                         portCBit3Out,
  output logic                         portCBit3Oe,
  input  wire logic                    port_c_bit4,
  output logic                         portCBit5Out,
  output logic                         portCBit5Oe
);
  import serial_oe_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] pinSync;
  logic       sckSync;
  logic       dinSync;
  logic       selSync;

  bit_sync #(
    .W (3)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .asyncIn ({port_a_bit5, port_c_bit4, portCBit3In}),
    .syncOut (pinSync)
  );

  assign sckSync = pinSync[0];
  assign dinSync = pinSync[1];
  assign selSync = pinSync[2];

  // ==========================================================================
  // State
  logic [7:0] dir_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic       sckPrev_reg;
  logic       busy_reg;
  logic       sckOut_reg;
  logic [6:0] divCnt_reg;
  logic [7:0] dirRd_next;
  logic       rxFull_next;

  // ==========================================================================
  // Decode
  wire isMaster    = cfg.enable && (cfg.mode <= MODE_MASTER_MAX);
  wire isSlaveSel  = cfg.enable && (cfg.mode == MODE_SLAVE_SEL);
  wire isSlaveNo   = cfg.enable && (cfg.mode == MODE_SLAVE_NOSEL);
  wire selRouted   = (cfg.pa5Func == PA5_SLAVE_SEL);
  // Select is active low; unrouted pin never deselects
  wire selHigh     = selRouted && selSync;
  wire slaveReset  = isSlaveSel && selHigh;
  wire cfgErrNext  = isSlaveNo && cfg.clockEdge;
  wire periphOe    = isMaster || isSlaveNo || (isSlaveSel && !selHigh);
  // Direction bit 5 reads the enable while the port owns the pin
  wire doutRdBit   = cfg.enable ? (!periphOe || dir_reg[DIR_DOUT_BIT])
                                : dir_reg[DIR_DOUT_BIT];

  always_comb begin
    dirRd_next               = dir_reg;
    dirRd_next[DIR_DOUT_BIT] = doutRdBit;
  end

  // ==========================================================================
  // Clock edges: internal in master mode, sampled pin in slave mode
  logic [6:0] halfDiv;
  always_comb begin
    unique case (cfg.mode[1:0])
      2'h0:    halfDiv = HALF_DIV_0;
      2'h1:    halfDiv = HALF_DIV_1;
      2'h2:    halfDiv = HALF_DIV_2;
      2'h3:    halfDiv = HALF_DIV_3;
    endcase
  end

  wire divWrap   = busy_reg && (divCnt_reg == halfDiv - 7'h01);
  wire mRise     = divWrap && !sckOut_reg;
  wire mFall     = divWrap && sckOut_reg;
  wire sRise     = sckSync && !sckPrev_reg;
  wire sFall     = !sckSync && sckPrev_reg;
  wire slaveOn   = (isSlaveSel && !selHigh) || isSlaveNo;
  wire rise      = isMaster ? mRise : (slaveOn && sRise);
  wire fall      = isMaster ? mFall : (slaveOn && sFall);
  // Edge select picks which edge samples and which presents
  wire sampleEdg = cfg.clockEdge ? fall : rise;
  wire shiftEdg  = cfg.clockEdge ? rise : fall;
  wire lastBit   = sampleEdg && (bitCnt_reg == BIT_LAST);
  wire idle      = (bitCnt_reg == 4'h0) && !busy_reg;
  wire loadOk    = txWrite && idle;
  wire collide   = txWrite && !idle;

  assign rxFull_next = lastBit || (status.rxFull && !rxRead);

  // ==========================================================================
  // Direction register: writes land as given, read-back feeds RMW
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dir_reg <= DIR_RESET_VAL;
    end else if (dirWrEn) begin
      dir_reg <= dirWrData;
    end
  end

  // ==========================================================================
  // Shift path
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg  <= 8'h00;
      bitCnt_reg <= 4'h0;
    end else if (loadOk) begin
      // Load beats select reset: a byte may be queued while deselected
      shift_reg  <= txData;
    end else if (slaveReset) begin
      bitCnt_reg <= 4'h0;
    end else if (sampleEdg) begin
      shift_reg  <= {shift_reg[6:0], dinSync};
      bitCnt_reg <= lastBit ? 4'h0 : bitCnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxData <= 8'h00;
    end else if (lastBit) begin
      rxData <= {shift_reg[6:0], dinSync};
    end
  end

  // ==========================================================================
  // Master clock generator
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg   <= 1'b0;
      sckOut_reg <= 1'b0;
      divCnt_reg <= 7'h00;
    end else if (!isMaster) begin
      busy_reg   <= 1'b0;
      sckOut_reg <= 1'b0;
      divCnt_reg <= 7'h00;
    end else begin
      if (loadOk) begin
        busy_reg <= 1'b1;
      // Stop only on a falling edge so the clock idles low
      end else if (lastBit && cfg.clockEdge) begin
        busy_reg <= 1'b0;
      end else if (busy_reg && bitCnt_reg == 4'h0 && mFall && !cfg.clockEdge) begin
        busy_reg <= 1'b0;
      end
      divCnt_reg <= divWrap ? 7'h00 : (busy_reg ? divCnt_reg + 7'h01 : 7'h00);
      if (divWrap) begin
        sckOut_reg <= !sckOut_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sckPrev_reg <= 1'b0;
    end else begin
      sckPrev_reg <= sckSync;
    end
  end

  // ==========================================================================
  // Status and read-back
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status    <= '0;
      dirRdData <= DIR_RESET_VAL;
    end else begin
      status.rxFull         <= rxFull_next;                   // Set beats clear
      status.writeCollision <= collide || (status.writeCollision && !txWrite);
      status.cfgError       <= cfgErrNext;
      status.periphOe       <= periphOe;
      dirRdData             <= dirRd_next;
    end
  end

  // ==========================================================================
  // Pin drivers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      portCBit3Out <= 1'b0;
      portCBit3Oe  <= 1'b0;
      portCBit5Out <= 1'b0;
      portCBit5Oe  <= 1'b0;
    end else begin
      portCBit3Out <= sckOut_reg;
      portCBit3Oe  <= isMaster && !dir_reg[DIR_SCK_BIT];
      if (loadOk || shiftEdg) begin
        portCBit5Out <= loadOk ? txData[7] : shift_reg[7];
      end
      // A set direction bit 5 silences the data pin
      portCBit5Oe  <= periphOe && !dir_reg[DIR_DOUT_BIT];
    end
  end

endmodule : spi_slave_select_oe_control
`default_nettype wire

// *** bench/spi_oe_assertions.sv ***
/* Checker for the select and output-enable block.
   Bound to the top module; watches its ports only. */
`timescale 1ns/1ps
`default_nettype none
module spi_oe_assertions (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  // Watched ports
  input wire serial_oe_pkg::port_cfg_t    cfg,
  input wire serial_oe_pkg::port_status_t status,
  input wire logic                    dirWrEn,
  input wire logic [7:0]              dirWrData,
  input wire logic [7:0]              dirRdData,
  input wire logic                    port_a_bit5,
  input wire logic                    portCBit3Oe,
  input wire logic                    portCBit5Oe
);
  import serial_oe_pkg::*;
  // ==========================================================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire slave = cfg.enable && cfg.mode == MODE_SLAVE_SEL;
  sequence s_selHigh;
    slave && cfg.pa5Func == PA5_SLAVE_SEL && port_a_bit5;
  endsequence
  sequence s_unrouted;
    slave && cfg.pa5Func != PA5_SLAVE_SEL;
  endsequence
  property p_selReset;
    s_selHigh [*4] |-> !$rose(status.rxFull);
  endproperty
  property p_oeRead;
    cfg.enable && $past(cfg.enable) && !status.periphOe |-> dirRdData[5];
  endproperty
  property p_rmw;
    dirWrEn && dirWrData[5] |-> ##2 dirRdData[5] && !portCBit5Oe;
  endproperty
  property p_unrouted;
    s_unrouted [*4] |-> status.periphOe;
  endproperty
  property p_clkOe;
    portCBit3Oe |-> $past(cfg.enable) && $past(cfg.mode) <= MODE_MASTER_MAX;
  endproperty
  property p_off;
    !cfg.enable [*3] |-> !portCBit5Oe && !portCBit3Oe;
  endproperty
  a_selReset: assert property (p_selReset) else $error("byte taken while deselected");
  a_oeRead:   assert property (p_oeRead) else $error("bit5 read-back ignores oe");
  a_rmw:      assert property (p_rmw) else $error("bit5 set left data out on");
  a_unrouted: assert property (p_unrouted) else $error("unrouted select not active");
  a_clkOe:    assert property (p_clkOe) else $error("clock driven outside master");
  a_off:      assert property (p_off) else $error("pins driven while disabled");
endmodule : spi_oe_assertions
bind spi_slave_select_oe_control spi_oe_assertions u_spi_oe_assertions (.clk_sys, .rst_b,
  .cfg, .status, .dirWrEn, .dirWrData, .dirRdData, .port_a_bit5, .portCBit3Oe, .portCBit5Oe);
`default_nettype wire

// *** bench/spi_master_model.sv ***
/* External SPI master: drives clock, select and data in.
   Assumes sampleFall matches the slave's clock-edge setting. */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  // Pins
  output logic      sck,
  output logic      selB,
  output logic      mosi,
  input  wire logic miso
);
  logic sampleFall = 1'b0;
  initial begin
    sck = 1'b0;
    selB = 1'b1;
    mosi = 1'b0;
  end
  // ==========================================================================
  // Frame of n bits, MSB first; clock idles low between frames
  task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    // Off-grid start keeps pin changes away from clk_sys edges
    #3;
    selB = 1'b0;
    #80;
    for (int i = 7; i > 7 - n; i--) begin
      // Data changes on the edge opposite to the sampling one
      if (!sampleFall) begin
        mosi = tx[i];
      end
      #80 sck = 1'b1;
      if (sampleFall) begin
        mosi = tx[i];
      end else begin
        rx[i] = miso;
      end
      #80 sck = 1'b0;
      if (sampleFall) begin
        rx[i] = miso;
      end
    end
    #80 selB = 1'b1;
    mosi = ~mosi; // Line inverted after the frame, so the last bit is not left on it
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

// *** bench/spi_slave_select_oe_control_tb.sv ***
/* Self-checking bench for the select and output-enable block.
   Assumes the master model on the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_select_oe_control_tb;
  import serial_oe_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_b = 1'b0;
  port_cfg_t    cfg = '0;
  port_status_t status;
  logic        dirWrEn = 1'b0;
  logic [7:0]  dirWrData = 8'h00;
  logic        txWrite = 1'b0;
  logic [7:0]  txData = 8'h00;
  logic        rxRead = 1'b0;
  logic [7:0]  dirRdData, rxData;
  logic        sck, selB, mosi, portCBit3Out, portCBit3Oe, portCBit5Out, portCBit5Oe;
  // Undriven data pin shows the inverse, so a missing enable is seen
  wire         misoPin = portCBit5Oe ? portCBit5Out : ~portCBit5Out;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  spi_slave_select_oe_control u_spi_slave_select_oe_control (.clk_sys, .rst_b, .cfg,
    .status, .dirWrEn, .dirWrData, .dirRdData, .txWrite, .txData, .rxRead, .rxData,
    .port_a_bit5(selB), .portCBit3In(sck), .portCBit3Out, .portCBit3Oe,
    .port_c_bit4(mosi), .portCBit5Out, .portCBit5Oe);
  spi_master_model u_spi_master_model (.sck, .selB, .mosi, .miso(misoPin));
  always #5 clk_sys = ~clk_sys;
  // ==========================================================================
  // Helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic set_cfg(input logic [3:0] m, input pa5_func_t f);
    @(posedge clk_sys);
    cfg <= '{1'b1, m, 1'b0, f};
  endtask : set_cfg
  task automatic wr_dir(input logic [7:0] d);
    @(posedge clk_sys);
    dirWrEn <= 1'b1;
    dirWrData <= d;
    @(posedge clk_sys);
    dirWrEn <= 1'b0;
    tick(2);
  endtask : wr_dir
  task automatic load(input logic [7:0] d);
    @(posedge clk_sys);
    txWrite <= 1'b1;
    txData <= d;
    @(posedge clk_sys);
    txWrite <= 1'b0;
  endtask : load
  task automatic take_rx(input logic [7:0] exp);
    for (int i = 0; i < 400 && status.rxFull !== 1'b1; i++) @(posedge clk_sys);
    check(rxData, exp);
    @(posedge clk_sys);
    rxRead <= 1'b1;
    @(posedge clk_sys);
    rxRead <= 1'b0;
    tick(2);
    check(8'(status.rxFull), 8'h00);
  endtask : take_rx
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check(dirRdData, 8'hff);
    check(8'(status), 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_xfer;
    logic [7:0] r;
    set_cfg(MODE_SLAVE_SEL, PA5_SLAVE_SEL);
    wr_dir(8'hdf);
    load(8'ha5);
    u_spi_master_model.frame(8'h3c, 8, r);
    take_rx(8'h3c);
    check(r, 8'ha5);
    check(dirRdData, 8'hff);
    $display("t_xfer done");
  endtask : t_xfer
  task automatic t_abort;
    logic [7:0] r;
    load(8'h81);
    u_spi_master_model.frame(8'h55, 4, r);
    tick(4);
    check(8'(status.rxFull), 8'h00);
    u_spi_master_model.frame(8'h69, 8, r);
    take_rx(8'h69);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_rmw;
    check(8'(status.periphOe), 8'h00);
    wr_dir(dirRdData);
    u_spi_master_model.selB = 1'b0;
    tick(5);
    check(8'(portCBit5Oe), 8'h00);
    wr_dir(8'hdf);
    tick(2);
    check(8'(portCBit5Oe), 8'h01);
    u_spi_master_model.selB = 1'b1;
    for (int k = 0; k < 2; k++) begin
      set_cfg(MODE_SLAVE_SEL, pa5_func_t'(k));
      tick(5);
      check(8'(status.periphOe), 8'h01);
    end
    $display("t_rmw done");
  endtask : t_rmw
  task automatic t_cke;
    logic [7:0] r;
    @(posedge clk_sys);
    cfg <= '{1'b1, MODE_SLAVE_SEL, 1'b1, PA5_SLAVE_SEL};
    load(8'h96);
    u_spi_master_model.sampleFall = 1'b1;
    u_spi_master_model.frame(8'h4b, 8, r);
    u_spi_master_model.sampleFall = 1'b0;
    take_rx(8'h4b);
    check(r, 8'h96);
    check(8'(status.cfgError), 8'h00);
    $display("t_cke done");
  endtask : t_cke
  task automatic t_master;
    logic p;
    int n;
    set_cfg(4'h0, PA5_GPIO);
    wr_dir(8'hd7);
    load(8'hc3);
    load(8'h3c);
    n = 0;
    p = portCBit3Out;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      n += int'(portCBit3Out !== p);
      p = portCBit3Out;
    end
    check(8'(n), 8'h10);
    check(8'(portCBit3Oe), 8'h01);
    check(8'(status.rxFull), 8'h01);
    check(8'(status.writeCollision), 8'h01);
    $display("t_master done");
  endtask : t_master
  // ==========================================================================
  // Run and verdict
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    tick(20);
    rst_b <= 1'b1;
    tick(3);
    t_reset();
    t_xfer();
    t_abort();
    t_rmw();
    t_cke();
    t_master();
    close_out();
  end
endmodule : spi_slave_select_oe_control_tb
`default_nettype wire
